// ### aod_pkg.sv
// constants for the arithmetic opcode decoder and its cycle-count lookup
// assumes one processor clock; counts are in processor clock cycles
package aod_pkg;

  // segment prefixes, segment code sits in opcode bits 4:3
  localparam logic [7:0] OPC_PFX_CS = 8'h2e;
  localparam logic [7:0] OPC_PFX_SS = 8'h36;
  localparam logic [7:0] OPC_PFX_DS = 8'h3e;
  localparam logic [7:0] OPC_PFX_ES = 8'h26;
  localparam int         SEG_LSB    = 3;

  // decimal and ascii adjusts
  localparam logic [7:0] OPC_UBCD_SUM  = 8'h37;
  localparam logic [7:0] OPC_PBCD_SUM  = 8'h27;
  localparam logic [7:0] OPC_UBCD_DIFF = 8'h3f;
  localparam logic [7:0] OPC_PBCD_DIFF = 8'h2f;

  // register forms and immediate group, opcode bits 7:2 (d or s, and w below)
  localparam logic [5:0] OPC_ADD_RM = 6'h00;
  localparam logic [5:0] OPC_ADC_RM = 6'h04;
  localparam logic [5:0] OPC_SBB_RM = 6'h06;
  localparam logic [5:0] OPC_SUB_RM = 6'h0a;
  localparam logic [5:0] OPC_GRP1   = 6'h20;

  // accumulator immediate forms and unary group, opcode bits 7:1
  localparam logic [6:0] OPC_ADD_ACC = 7'h02;
  localparam logic [6:0] OPC_ADC_ACC = 7'h0a;
  localparam logic [6:0] OPC_SBB_ACC = 7'h0e;
  localparam logic [6:0] OPC_SUB_ACC = 7'h16;
  localparam logic [6:0] OPC_GRP3    = 7'h7b;

  // modrm reg sub-opcodes
  localparam logic [2:0] SUB_ADD = 3'h0;
  localparam logic [2:0] SUB_ADC = 3'h2;
  localparam logic [2:0] SUB_SBB = 3'h3;
  localparam logic [2:0] SUB_SUB = 3'h5;
  localparam logic [2:0] SUB_NEG = 3'h3;
  localparam logic [2:0] SUB_MUL = 3'h4;
  localparam logic [1:0] MOD_REG = 2'h3;
  localparam logic [1:0] MOD_D8  = 2'h1;
  localparam logic [1:0] MOD_D16 = 2'h2;
  localparam logic [2:0] RM_DIRECT = 3'h6;

  // cycle counts
  localparam int CW = 6;
  localparam logic [CW-1:0] CYC_PFX      = 6'h02;
  localparam logic [CW-1:0] CYC_RM_REG   = 6'h03;
  localparam logic [CW-1:0] CYC_RM_MEM   = 6'h0a;
  localparam logic [CW-1:0] CYC_IMM_REG  = 6'h04;
  localparam logic [CW-1:0] CYC_IMM_MEM  = 6'h10;
  localparam logic [CW-1:0] CYC_ACC_B    = 6'h03;
  localparam logic [CW-1:0] CYC_ACC_W    = 6'h04;
  localparam logic [CW-1:0] CYC_UBCD_SUM = 6'h08;
  localparam logic [CW-1:0] CYC_PBCD     = 6'h04;
  localparam logic [CW-1:0] CYC_UBCD_DIF = 6'h07;
  localparam logic [CW-1:0] CYC_MUL_RB_LO = 6'h1a;
  localparam logic [CW-1:0] CYC_MUL_RB_HI = 6'h1c;
  localparam logic [CW-1:0] CYC_MUL_RW_LO = 6'h23;
  localparam logic [CW-1:0] CYC_MUL_RW_HI = 6'h25;
  localparam logic [CW-1:0] CYC_MUL_MB_LO = 6'h20;
  localparam logic [CW-1:0] CYC_MUL_MB_HI = 6'h22;
  localparam logic [CW-1:0] CYC_MUL_MW_LO = 6'h29;
  localparam logic [CW-1:0] CYC_MUL_MW_HI = 6'h2b;
  localparam logic [CW-1:0] CYC_NARROW_ADD = 6'h04;
  localparam logic [CW-1:0] CYC_BAD        = 6'h01;

  typedef enum logic [3:0] {
    K_BAD  = 4'h0, K_PFX  = 4'h1, K_RM   = 4'h2, K_IMM  = 4'h3,
    K_ACC  = 4'h4, K_NEG  = 4'h5, K_UBSA = 4'h6, K_PBSA = 4'h7,
    K_UBDA = 4'h8, K_PBDA = 4'h9, K_MUL  = 4'ha
  } aod_kind_e;

  typedef enum logic [1:0] {
    F_ADD = 2'h0, F_ADC = 2'h1, F_SUB = 2'h2, F_SBB = 2'h3
  } aod_fn_e;

endpackage

// ### aod_timing_if.sv
// carries operand class to the cycle lookup and the counts back
// assumes both ends sit on the processor clock
`timescale 1ns/10ps
`default_nettype none
interface aod_timing_if;
  aod_pkg::aod_kind_e      kind;
  logic                    mem;
  logic                    word;
  logic                    narrow;
  logic [aod_pkg::CW-1:0]  cyc_min;
  logic [aod_pkg::CW-1:0]  cyc_max;
  modport dec (output kind, output mem, output word, output narrow,
               input cyc_min, input cyc_max);
  modport tim (input kind, input mem, input word, input narrow,
               output cyc_min, output cyc_max);
endinterface
`default_nettype wire

// ### aod_timing.sv
// cycle-count lookup for the decoded arithmetic instructions
// assumes the decoder presents operand class in the cycle it needs counts
`timescale 1ns/10ps
`default_nettype none
module aod_timing (
  // operand class in, counts out
  aod_timing_if.tim t
);
  logic [aod_pkg::CW-1:0] lo;
  logic [aod_pkg::CW-1:0] hi;
  logic                   wmem;

  always_comb begin
    wmem = t.mem & t.word & t.narrow;
    lo = aod_pkg::CYC_BAD;
    hi = aod_pkg::CYC_BAD;
    case (t.kind)
      aod_pkg::K_PFX: begin
        lo = aod_pkg::CYC_PFX;
        hi = aod_pkg::CYC_PFX;
      end
      aod_pkg::K_RM, aod_pkg::K_NEG: begin
        lo = t.mem ? aod_pkg::CYC_RM_MEM : aod_pkg::CYC_RM_REG;
        hi = lo;
      end
      aod_pkg::K_IMM: begin
        lo = t.mem ? aod_pkg::CYC_IMM_MEM : aod_pkg::CYC_IMM_REG;
        hi = lo;
      end
      aod_pkg::K_ACC: begin
        lo = t.word ? aod_pkg::CYC_ACC_W : aod_pkg::CYC_ACC_B;
        hi = lo;
      end
      aod_pkg::K_UBSA: begin
        lo = aod_pkg::CYC_UBCD_SUM;
        hi = lo;
      end
      aod_pkg::K_PBSA, aod_pkg::K_PBDA: begin
        lo = aod_pkg::CYC_PBCD;
        hi = lo;
      end
      aod_pkg::K_UBDA: begin
        lo = aod_pkg::CYC_UBCD_DIF;
        hi = lo;
      end
      aod_pkg::K_MUL: begin
        if (t.mem && t.word) begin
          lo = aod_pkg::CYC_MUL_MW_LO;
          hi = aod_pkg::CYC_MUL_MW_HI;
        end else if (t.mem) begin
          lo = aod_pkg::CYC_MUL_MB_LO;
          hi = aod_pkg::CYC_MUL_MB_HI;
        end else if (t.word) begin
          lo = aod_pkg::CYC_MUL_RW_LO;
          hi = aod_pkg::CYC_MUL_RW_HI;
        end else begin
          lo = aod_pkg::CYC_MUL_RB_LO;
          hi = aod_pkg::CYC_MUL_RB_HI;
        end
      end
      default: begin
        lo = aod_pkg::CYC_BAD;
        hi = aod_pkg::CYC_BAD;
      end
    endcase
    // accumulator forms never move memory, so wmem is low for them
    if (wmem && t.kind != aod_pkg::K_BAD) begin
      lo = lo + aod_pkg::CYC_NARROW_ADD;
      hi = hi + aod_pkg::CYC_NARROW_ADD;
    end
  end

  assign t.cyc_min = lo;
  assign t.cyc_max = hi;
endmodule
`default_nettype wire

// ### aod_top.sv
// arithmetic opcode decoder with execution cycle model
// assumes bytes arrive from the prefetch queue by valid/ready on ref_clk
`timescale 1ns/10ps
`default_nettype none
module aod_top (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // bus variant strap, high for the 8-bit bus part
  input  wire logic        narrow_bus,
  // prefetch queue
  input  wire logic        q_valid,
  input  wire logic [7:0]  q_byte,
  output logic             q_ready,
  // decoded instruction, valid with done
  output logic             done,
  output logic             bad_op,
  output logic [3:0]       op_kind,
  output logic [1:0]       op_fn,
  output logic             op_word,
  output logic             op_mem,
  output logic             seg_valid,
  output logic [1:0]       seg_code,
  output logic [15:0]      op_imm,
  output logic [5:0]       cyc_min,
  output logic [5:0]       cyc_max,
  output logic             busy
);
  typedef enum logic [4:0] {
    S_OP    = 5'b00001,
    S_MODRM = 5'b00010,
    S_DISP  = 5'b00100,
    S_IMM   = 5'b01000,
    S_EXEC  = 5'b10000
  } aod_state_e;

  aod_state_e          state_r, state_nxt;
  aod_pkg::aod_kind_e  kind_r, kind_nxt;
  aod_pkg::aod_fn_e    fn_r, fn_nxt;
  logic                word_r, word_nxt;
  logic                mem_r, mem_nxt;
  logic                sx_r, sx_nxt;
  logic [1:0]          grp_r, grp_nxt;
  logic [1:0]          disp_r, disp_nxt;
  logic [1:0]          imm_left_r, imm_left_nxt;
  logic                imm_hi_r, imm_hi_nxt;
  logic [15:0]         imm_r, imm_nxt;
  logic [1:0]          seg_r, seg_nxt;
  logic                seg_v_r, seg_v_nxt;
  logic [5:0]          cnt_r, cnt_nxt;
  logic [5:0]          cmin_r, cmin_nxt;
  logic [5:0]          cmax_r, cmax_nxt;
  logic                rdy_r, rdy_nxt;
  logic                done_r, done_nxt;
  logic                bad_r, bad_nxt;
  logic                osegv_r, osegv_nxt;
  logic                take;
  logic [1:0]          dcnt;
  logic [1:0]          icnt;

  aod_timing_if tif ();

  aod_timing u_timing (
    .t (tif.tim)
  );

  // counts are looked up from next-state class so entry loads in one step
  assign tif.kind   = kind_nxt;
  assign tif.mem    = mem_nxt;
  assign tif.word   = word_nxt;
  assign tif.narrow = narrow_bus;

  assign take = q_valid & rdy_r;

  always_comb begin
    state_nxt    = state_r;
    kind_nxt     = kind_r;
    fn_nxt       = fn_r;
    word_nxt     = word_r;
    mem_nxt      = mem_r;
    sx_nxt       = sx_r;
    grp_nxt      = grp_r;
    disp_nxt     = disp_r;
    imm_left_nxt = imm_left_r;
    imm_hi_nxt   = imm_hi_r;
    imm_nxt      = imm_r;
    seg_nxt      = seg_r;
    seg_v_nxt    = seg_v_r;
    done_nxt     = 1'b0;
    bad_nxt      = 1'b0;
    osegv_nxt    = osegv_r;
    dcnt         = 2'h0;
    icnt         = 2'h0;
    case (state_r)
      S_OP: begin
        if (take) begin
          kind_nxt = aod_pkg::K_BAD;
          fn_nxt   = aod_pkg::F_ADD;
          word_nxt = q_byte[0];
          mem_nxt  = 1'b0;
          sx_nxt   = q_byte[1];
          grp_nxt  = 2'h0;
          imm_nxt  = 16'h0000;
          imm_hi_nxt = 1'b0;
          state_nxt  = S_EXEC;
          if (q_byte == aod_pkg::OPC_PFX_CS || q_byte == aod_pkg::OPC_PFX_SS ||
              q_byte == aod_pkg::OPC_PFX_DS || q_byte == aod_pkg::OPC_PFX_ES) begin
            kind_nxt = aod_pkg::K_PFX;
            word_nxt = 1'b0;
          end else if (q_byte == aod_pkg::OPC_UBCD_SUM) begin
            kind_nxt = aod_pkg::K_UBSA;
            word_nxt = 1'b0;
          end else if (q_byte == aod_pkg::OPC_PBCD_SUM) begin
            kind_nxt = aod_pkg::K_PBSA;
            word_nxt = 1'b0;
          end else if (q_byte == aod_pkg::OPC_UBCD_DIFF) begin
            kind_nxt = aod_pkg::K_UBDA;
            word_nxt = 1'b0;
          end else if (q_byte == aod_pkg::OPC_PBCD_DIFF) begin
            kind_nxt = aod_pkg::K_PBDA;
            word_nxt = 1'b0;
          end else if (q_byte[7:2] == aod_pkg::OPC_ADD_RM ||
                       q_byte[7:2] == aod_pkg::OPC_ADC_RM ||
                       q_byte[7:2] == aod_pkg::OPC_SBB_RM ||
                       q_byte[7:2] == aod_pkg::OPC_SUB_RM) begin
            kind_nxt  = aod_pkg::K_RM;
            state_nxt = S_MODRM;
            if (q_byte[7:2] == aod_pkg::OPC_ADC_RM) begin
              fn_nxt = aod_pkg::F_ADC;
            end else if (q_byte[7:2] == aod_pkg::OPC_SUB_RM) begin
              fn_nxt = aod_pkg::F_SUB;
            end else if (q_byte[7:2] == aod_pkg::OPC_SBB_RM) begin
              fn_nxt = aod_pkg::F_SBB;
            end
          end else if (q_byte[7:1] == aod_pkg::OPC_ADD_ACC ||
                       q_byte[7:1] == aod_pkg::OPC_ADC_ACC ||
                       q_byte[7:1] == aod_pkg::OPC_SBB_ACC ||
                       q_byte[7:1] == aod_pkg::OPC_SUB_ACC) begin
            kind_nxt     = aod_pkg::K_ACC;
            imm_left_nxt = q_byte[0] ? 2'h2 : 2'h1;
            sx_nxt       = 1'b0;
            state_nxt    = S_IMM;
            if (q_byte[7:1] == aod_pkg::OPC_ADC_ACC) begin
              fn_nxt = aod_pkg::F_ADC;
            end else if (q_byte[7:1] == aod_pkg::OPC_SUB_ACC) begin
              fn_nxt = aod_pkg::F_SUB;
            end else if (q_byte[7:1] == aod_pkg::OPC_SBB_ACC) begin
              fn_nxt = aod_pkg::F_SBB;
            end
          end else if (q_byte[7:2] == aod_pkg::OPC_GRP1) begin
            grp_nxt   = 2'h1;
            state_nxt = S_MODRM;
          end else if (q_byte[7:1] == aod_pkg::OPC_GRP3) begin
            grp_nxt   = 2'h2;
            state_nxt = S_MODRM;
          end
        end
      end
      S_MODRM: begin
        if (take) begin
          mem_nxt = q_byte[7:6] != aod_pkg::MOD_REG;
          if (q_byte[7:6] == aod_pkg::MOD_D8) begin
            dcnt = 2'h1;
          end else if (q_byte[7:6] == aod_pkg::MOD_D16) begin
            dcnt = 2'h2;
          end else if (q_byte[7:6] == 2'h0 && q_byte[2:0] == aod_pkg::RM_DIRECT) begin
            dcnt = 2'h2;
          end
          if (grp_r == 2'h1) begin
            kind_nxt = aod_pkg::K_IMM;
            // s=1 w=1 takes one byte and widens it
            icnt = (!sx_r && word_r) ? 2'h2 : 2'h1;
            if (q_byte[5:3] == aod_pkg::SUB_ADD) begin
              fn_nxt = aod_pkg::F_ADD;
            end else if (q_byte[5:3] == aod_pkg::SUB_ADC) begin
              fn_nxt = aod_pkg::F_ADC;
            end else if (q_byte[5:3] == aod_pkg::SUB_SUB) begin
              fn_nxt = aod_pkg::F_SUB;
            end else if (q_byte[5:3] == aod_pkg::SUB_SBB) begin
              fn_nxt = aod_pkg::F_SBB;
            end else begin
              kind_nxt = aod_pkg::K_BAD;
            end
          end else if (grp_r == 2'h2) begin
            if (q_byte[5:3] == aod_pkg::SUB_NEG) begin
              kind_nxt = aod_pkg::K_NEG;
            end else if (q_byte[5:3] == aod_pkg::SUB_MUL) begin
              kind_nxt = aod_pkg::K_MUL;
            end else begin
              kind_nxt = aod_pkg::K_BAD;
            end
          end
          // unsupported sub-opcodes still swallow their displacement
          disp_nxt     = dcnt;
          imm_left_nxt = icnt;
          if (dcnt != 2'h0) begin
            state_nxt = S_DISP;
          end else if (icnt != 2'h0) begin
            state_nxt = S_IMM;
          end else begin
            state_nxt = S_EXEC;
          end
        end
      end
      S_DISP: begin
        if (take) begin
          disp_nxt = disp_r - 2'h1;
          if (disp_r == 2'h1) begin
            state_nxt = (imm_left_r != 2'h0) ? S_IMM : S_EXEC;
          end
        end
      end
      S_IMM: begin
        if (take) begin
          imm_left_nxt = imm_left_r - 2'h1;
          imm_hi_nxt   = 1'b1;
          if (imm_hi_r) begin
            imm_nxt[15:8] = q_byte;
          end else begin
            imm_nxt[7:0]  = q_byte;
            imm_nxt[15:8] = (sx_r && word_r) ? {8{q_byte[7]}} : 8'h00;
          end
          if (imm_left_r == 2'h1) begin
            state_nxt = S_EXEC;
          end
        end
      end
      S_EXEC: begin
        if (cnt_r == 6'h00) begin
          done_nxt  = 1'b1;
          bad_nxt   = kind_r == aod_pkg::K_BAD;
          osegv_nxt = seg_v_r;
          state_nxt = S_OP;
          seg_v_nxt = kind_r == aod_pkg::K_PFX;
        end
      end
      default: begin
        state_nxt = S_OP;
      end
    endcase
    // the prefix seg code is held for the instruction it overrides
    if (state_r == S_OP && take && kind_nxt == aod_pkg::K_PFX) begin
      seg_nxt = q_byte[aod_pkg::SEG_LSB +: 2];
    end
    rdy_nxt = state_nxt != S_EXEC;
  end

  // the counter has its own process so the count lookup closes no loop
  always_comb begin
    cnt_nxt  = cnt_r;
    cmin_nxt = cmin_r;
    cmax_nxt = cmax_r;
    // exec runs the longest count; the range is reported, not modelled
    if (state_r != S_EXEC && state_nxt == S_EXEC) begin
      cnt_nxt  = tif.cyc_max - 6'h01;
      cmin_nxt = tif.cyc_min;
      cmax_nxt = tif.cyc_max;
    end else if (state_r == S_EXEC && cnt_r != 6'h00) begin
      cnt_nxt = cnt_r - 6'h01;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_r    <= S_OP;
      kind_r     <= aod_pkg::K_BAD;
      fn_r       <= aod_pkg::F_ADD;
      word_r     <= 1'b0;
      mem_r      <= 1'b0;
      sx_r       <= 1'b0;
      grp_r      <= 2'h0;
      disp_r     <= 2'h0;
      imm_left_r <= 2'h0;
      imm_hi_r   <= 1'b0;
      imm_r      <= 16'h0000;
      seg_r      <= 2'h0;
      seg_v_r    <= 1'b0;
      cnt_r      <= 6'h00;
      cmin_r     <= 6'h00;
      cmax_r     <= 6'h00;
      rdy_r      <= 1'b0;
      done_r     <= 1'b0;
      bad_r      <= 1'b0;
      osegv_r    <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      kind_r     <= kind_nxt;
      fn_r       <= fn_nxt;
      word_r     <= word_nxt;
      mem_r      <= mem_nxt;
      sx_r       <= sx_nxt;
      grp_r      <= grp_nxt;
      disp_r     <= disp_nxt;
      imm_left_r <= imm_left_nxt;
      imm_hi_r   <= imm_hi_nxt;
      imm_r      <= imm_nxt;
      seg_r      <= seg_nxt;
      seg_v_r    <= seg_v_nxt;
      cnt_r      <= cnt_nxt;
      cmin_r     <= cmin_nxt;
      cmax_r     <= cmax_nxt;
      rdy_r      <= rdy_nxt;
      done_r     <= done_nxt;
      bad_r      <= bad_nxt;
      osegv_r    <= osegv_nxt;
    end
  end

  assign q_ready   = rdy_r;
  assign done      = done_r;
  assign bad_op    = bad_r;
  assign op_kind   = kind_r;
  assign op_fn     = fn_r;
  assign op_word   = word_r;
  assign op_mem    = mem_r;
  assign seg_valid = osegv_r;
  assign seg_code  = seg_r;
  assign op_imm    = imm_r;
  assign cyc_min   = cmin_r;
  assign cyc_max   = cmax_r;
  assign busy      = state_r == S_EXEC;
endmodule
`default_nettype wire

// ### aod_checker.sv
// port assertions for the arithmetic opcode decoder
// assumes narrow_bus stays steady while an instruction runs
`timescale 1ns/10ps
`default_nettype none
module aod_checker (
  // clock and reset
  input wire logic       ref_clk,
  input wire logic       rst,
  // strap
  input wire logic       narrow_bus,
  // decoded result
  input wire logic       done,
  input wire logic [3:0] op_kind,
  input wire logic       op_word,
  input wire logic       op_mem,
  input wire logic [5:0] cyc_min,
  input wire logic [5:0] cyc_max,
  input wire logic       busy
);
  logic [6:0] busy_cnt_r;
  logic [6:0] busy_cnt_nxt;
  logic       nw;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // extra word cycles only where the bus is narrow
  assign nw = narrow_bus & op_word;
  always_comb begin
    busy_cnt_nxt = busy ? busy_cnt_r + 7'h01 : 7'h00;
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      busy_cnt_r <= 7'h00;
    end else begin
      busy_cnt_r <= busy_cnt_nxt;
    end
  end
  prefix_count_a: assert property (done && op_kind == 4'h1 |-> cyc_min == 6'h02 && cyc_max == 6'h02)
    else $error("prefix count wrong");
  reg_count_a: assert property (done && op_kind == 4'h2 && !op_mem |-> cyc_min == 6'h03 && cyc_max == 6'h03)
    else $error("register form count wrong");
  reg_mem_a: assert property (done && op_kind == 4'h2 && op_mem |-> cyc_max == (nw ? 6'h0e : 6'h0a))
    else $error("register form memory count wrong");
  imm_count_a: assert property (done && op_kind == 4'h3 |-> cyc_max == (op_mem ? (nw ? 6'h14 : 6'h10) : 6'h04))
    else $error("immediate group count wrong");
  acc_count_a: assert property (done && op_kind == 4'h4 |-> cyc_max == (op_word ? 6'h04 : 6'h03))
    else $error("accumulator count wrong");
  flip_count_a: assert property (done && op_kind == 4'h5 |-> cyc_max == (op_mem ? (nw ? 6'h0e : 6'h0a) : 6'h03))
    else $error("sign flip count wrong");
  adjust_count_a: assert property (done && op_kind >= 4'h6 && op_kind <= 4'h9 |-> cyc_max == (op_kind == 4'h6 ? 6'h08 : op_kind == 4'h8 ? 6'h07 : 6'h04))
    else $error("adjust count wrong");
  product_range_a: assert property (done && op_kind == 4'ha |-> cyc_min == cyc_max - 6'h02 && cyc_max == (!op_mem ? (op_word ? 6'h25 : 6'h1c) : (op_word ? (narrow_bus ? 6'h2f : 6'h2b) : 6'h22)))
    else $error("product range wrong");
  exec_len_a: assert property (done |-> busy_cnt_r == {1'b0, cyc_max} ##1 !done)
    else $error("exec length differs from count");
endmodule
bind aod_top aod_checker i_aod_checker (.ref_clk(ref_clk), .rst(rst), .narrow_bus(narrow_bus),
  .done(done), .op_kind(op_kind), .op_word(op_word), .op_mem(op_mem), .cyc_min(cyc_min),
  .cyc_max(cyc_max), .busy(busy));
`default_nettype wire

// ### aod_queue_model.sv
// behavioural prefetch queue feeding the decoder one byte per handshake
// assumes the bench loads bytes; stall models a slow bus unit
`timescale 1ns/10ps
`default_nettype none
module aod_queue_model (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // bench loading side
  input  wire logic       ld_en,
  input  wire logic [7:0] ld_byte,
  input  wire logic       stall,
  // queue side
  input  wire logic       q_ready,
  output logic            q_valid,
  output logic [7:0]      q_byte
);
  logic [7:0] fifo [$];
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      fifo.delete();
      q_valid <= 1'b0;
      q_byte  <= 8'h00;
    end else begin
      if (q_valid && q_ready) begin
        void'(fifo.pop_front());
      end
      if (ld_en) begin
        fifo.push_back(ld_byte);
      end
      if (!stall && fifo.size() > 0) begin
        q_valid <= 1'b1;
        q_byte  <= fifo[0];
      end else begin
        // the last byte is inverted on the lines every idle cycle
        q_valid <= 1'b0;
        q_byte  <= ~q_byte;
      end
    end
  end
endmodule
`default_nettype wire

// ### arith_opcode_decode_timing_test.sv
// self-checking bench for the arithmetic opcode decoder
// assumes aod_top, the queue model and the checker are compiled before it
`timescale 1ns/10ps
`default_nettype none
module arith_opcode_decode_timing_test;
  logic        ref_clk, rst, narrow_bus, q_valid, q_ready, ld_en, stall, slow;
  logic        done, bad_op, op_word, op_mem, seg_valid, busy, exp_sv;
  logic [7:0]  q_byte, ld_byte;
  logic [3:0]  op_kind;
  logic [1:0]  op_fn, seg_code, exp_sc;
  logic [15:0] op_imm;
  logic [5:0]  cyc_min, cyc_max;
  int          err_total, num_checks;
  logic [7:0]  rm_base [4] = '{8'h00, 8'h10, 8'h28, 8'h18};
  logic [7:0]  acc_base [4] = '{8'h04, 8'h14, 8'h2c, 8'h1c};
  logic [7:0]  sub_fld [4] = '{8'h00, 8'h10, 8'h28, 8'h18};

  aod_top i_aod_top (.ref_clk(ref_clk), .rst(rst), .narrow_bus(narrow_bus), .q_valid(q_valid),
    .q_byte(q_byte), .q_ready(q_ready), .done(done), .bad_op(bad_op), .op_kind(op_kind),
    .op_fn(op_fn), .op_word(op_word), .op_mem(op_mem), .seg_valid(seg_valid),
    .seg_code(seg_code), .op_imm(op_imm), .cyc_min(cyc_min), .cyc_max(cyc_max), .busy(busy));
  aod_queue_model i_aod_queue_model (.ref_clk(ref_clk), .rst(rst), .ld_en(ld_en),
    .ld_byte(ld_byte), .stall(stall), .q_ready(q_ready), .q_valid(q_valid), .q_byte(q_byte));

  always #20 ref_clk = ~ref_clk;

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic set_narrow(input logic v);
    @(posedge ref_clk);
    narrow_bus <= v;
  endtask

  // bytes go low byte first; waits for done under a bound, counting exec cycles
  task automatic do_op(input logic [47:0] bv, input int n, input logic [3:0] k,
    input logic [1:0] fn, input logic w, input logic m, input logic [5:0] cmin,
    input logic [5:0] cmax, input logic [15:0] imm);
    int cnt;
    int t;
    int rb;
    cnt = 0;
    rb = 0;
    for (int i = 0; i < n; i++) begin
      @(posedge ref_clk);
      ld_en   <= 1'b1;
      ld_byte <= bv[8*i +: 8];
      stall   <= slow && (i % 2 == 0);
    end
    @(posedge ref_clk);
    ld_en <= 1'b0;
    stall <= 1'b0;
    for (t = 0; t < 200 && done !== 1'b1; t++) begin
      @(posedge ref_clk);
      #1;
      if (busy === 1'b1) cnt++;
      if (busy === 1'b1 && q_ready !== 1'b0) rb++;
    end
    chk("done", 16'h0001, {15'h0, done});
    chk("bad_op", {15'h0, k == 4'h0}, {15'h0, bad_op});
    chk("op_kind", {12'h0, k}, {12'h0, op_kind});
    chk("cyc_min", {10'h0, cmin}, {10'h0, cyc_min});
    chk("cyc_max", {10'h0, cmax}, {10'h0, cyc_max});
    chk("exec_cycles", {10'h0, cmax}, 16'(cnt));
    chk("q_ready_busy", 16'h0000, 16'(rb));
    chk("q_ready_done", 16'h0001, {15'h0, q_ready});
    chk("seg_valid", {15'h0, exp_sv}, {15'h0, seg_valid});
    if (exp_sv) chk("seg_code", {14'h0, exp_sc}, {14'h0, seg_code});
    if (k != 4'h0) begin
      chk("op_fn", {14'h0, fn}, {14'h0, op_fn});
      chk("op_word", {15'h0, w}, {15'h0, op_word});
      chk("op_mem", {15'h0, m}, {15'h0, op_mem});
    end
    if (k == 4'h3 || k == 4'h4) chk("op_imm", imm, op_imm);
    exp_sv = 1'b0;
  endtask

  task automatic t_prefix();
    logic [7:0] pf [4] = '{8'h26, 8'h2e, 8'h36, 8'h3e};
    for (int i = 0; i < 4; i++) begin
      do_op(pf[i], 1, 4'h1, 2'h0, 1'b0, 1'b0, 6'h02, 6'h02, 16'h0);
      exp_sv = 1'b1;
      exp_sc = 2'(i);
      do_op(8'h27, 1, 4'h7, 2'h0, 1'b0, 1'b0, 6'h04, 6'h04, 16'h0);
    end
  endtask

  task automatic t_adjust();
    logic [7:0] op [4] = '{8'h37, 8'h27, 8'h3f, 8'h2f};
    logic [5:0] cy [4] = '{6'h08, 6'h04, 6'h07, 6'h04};
    for (int i = 0; i < 4; i++) begin
      do_op(op[i], 1, 4'(6 + i), 2'h0, 1'b0, 1'b0, cy[i], cy[i], 16'h0);
    end
  endtask

  task automatic t_regform();
    for (int f = 0; f < 4; f++) begin
      do_op({8'hc0, rm_base[f]}, 2, 4'h2, 2'(f), 1'b0, 1'b0, 6'h03, 6'h03, 16'h0);
      do_op({8'h12, 8'h45, rm_base[f] | 8'h01}, 3, 4'h2, 2'(f), 1'b1, 1'b1, 6'h0a, 6'h0a, 16'h0);
      set_narrow(1'b1);
      do_op({8'h12, 8'h45, rm_base[f] | 8'h01}, 3, 4'h2, 2'(f), 1'b1, 1'b1, 6'h0e, 6'h0e, 16'h0);
      set_narrow(1'b0);
    end
  endtask

  task automatic t_immgrp();
    for (int f = 0; f < 4; f++) begin
      do_op({8'h12, 8'h34, 8'hc0 | sub_fld[f], 8'h81}, 4, 4'h3, 2'(f), 1'b1, 1'b0, 6'h04, 6'h04, 16'h1234);
      slow = 1'b1;
      do_op({8'h80, 8'hc0 | sub_fld[f], 8'h83}, 3, 4'h3, 2'(f), 1'b1, 1'b0, 6'h04, 6'h04, 16'hff80);
      slow = 1'b0;
      do_op({8'h55, 8'h22, 8'h11, 8'h06 | sub_fld[f], 8'h80}, 5, 4'h3, 2'(f), 1'b0, 1'b1, 6'h10, 6'h10, 16'h0055);
      set_narrow(1'b1);
      do_op({8'h9a, 8'h78, 8'h09, 8'h40 | sub_fld[f], 8'h81}, 5, 4'h3, 2'(f), 1'b1, 1'b1, 6'h14, 6'h14, 16'h9a78);
      set_narrow(1'b0);
    end
    // s=1 w=0 takes one byte and leaves the high byte clear
    do_op({8'h80, 8'hc0, 8'h82}, 3, 4'h3, 2'h0, 1'b0, 1'b0, 6'h04, 6'h04, 16'h0080);
    // a refused sub-opcode must still swallow two displacement bytes and its data
    do_op({8'h55, 8'h22, 8'h11, 8'h8b, 8'h80}, 5, 4'h0, 2'h0, 1'b0, 1'b0, 6'h01, 6'h01, 16'h0);
  endtask

  task automatic t_acc();
    for (int f = 0; f < 4; f++) begin
      do_op({8'h7e, acc_base[f]}, 2, 4'h4, 2'(f), 1'b0, 1'b0, 6'h03, 6'h03, 16'h007e);
      do_op({8'hbe, 8'hef, acc_base[f] | 8'h01}, 3, 4'h4, 2'(f), 1'b1, 1'b0, 6'h04, 6'h04, 16'hbeef);
    end
  endtask

  task automatic t_flip_product();
    do_op({8'hd8, 8'hf6}, 2, 4'h5, 2'h0, 1'b0, 1'b0, 6'h03, 6'h03, 16'h0);
    do_op({8'h02, 8'h01, 8'h1e, 8'hf7}, 4, 4'h5, 2'h0, 1'b1, 1'b1, 6'h0a, 6'h0a, 16'h0);
    do_op({8'he0, 8'hf6}, 2, 4'ha, 2'h0, 1'b0, 1'b0, 6'h1a, 6'h1c, 16'h0);
    do_op({8'he0, 8'hf7}, 2, 4'ha, 2'h0, 1'b1, 1'b0, 6'h23, 6'h25, 16'h0);
    do_op({8'h02, 8'h01, 8'h26, 8'hf6}, 4, 4'ha, 2'h0, 1'b0, 1'b1, 6'h20, 6'h22, 16'h0);
    do_op({8'h02, 8'h01, 8'h26, 8'hf7}, 4, 4'ha, 2'h0, 1'b1, 1'b1, 6'h29, 6'h2b, 16'h0);
    set_narrow(1'b1);
    do_op({8'h02, 8'h01, 8'h26, 8'hf7}, 4, 4'ha, 2'h0, 1'b1, 1'b1, 6'h2d, 6'h2f, 16'h0);
    do_op({8'h02, 8'h01, 8'h1e, 8'hf7}, 4, 4'h5, 2'h0, 1'b1, 1'b1, 6'h0e, 6'h0e, 16'h0);
    do_op(8'h37, 1, 4'h6, 2'h0, 1'b0, 1'b0, 6'h08, 6'h08, 16'h0);
    set_narrow(1'b0);
    // unhandled codes come back flagged with the shortest count
    do_op(8'h0f, 1, 4'h0, 2'h0, 1'b0, 1'b0, 6'h01, 6'h01, 16'h0);
    do_op({8'hf0, 8'hf6}, 2, 4'h0, 2'h0, 1'b0, 1'b0, 6'h01, 6'h01, 16'h0);
  endtask

  task automatic t_reset();
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    chk("q_ready_rst", 16'h0000, {15'h0, q_ready});
    chk("op_kind_rst", 16'h0000, {12'h0, op_kind});
    @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    #1;
    chk("q_ready_rel", 16'h0001, {15'h0, q_ready});
    do_op(8'h2f, 1, 4'h9, 2'h0, 1'b0, 1'b0, 6'h04, 6'h04, 16'h0);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    ref_clk = 1'b0; rst = 1'b1; narrow_bus = 1'b0; ld_en = 1'b0; ld_byte = 8'h00;
    stall = 1'b0; slow = 1'b0; exp_sv = 1'b0; exp_sc = 2'h0;
    err_total = 0; num_checks = 0;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    t_prefix();
    t_adjust();
    t_reset();
    t_regform();
    t_immgrp();
    t_acc();
    t_flip_product();
    results();
  end

  // 62 instructions of under 60 cycles each fit well inside this span
  initial begin
    #800000;
    err_total++;
    results();
  end
endmodule
`default_nettype wire
